// [dv/cgmo_i2c_host.sv]
// two-wire host model that programs the register bank
module cgmo_i2c_host (
  input  wire logic i_sys_clk,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  import cgmo_pkg::*;
  logic sda_lo = 1'b0;
  // pull-up on the data line: a released line reads high
  assign o_sda = ~(sda_lo | i_sda_oe);
  initial o_scl = 1'b1;

  task automatic tick(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // bit level
  // ----------------------------------------------------------------
  // four clocks a half bit leaves room for the device's output latency
  task automatic put_bit(logic b);
    sda_lo = ~b;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    o_scl = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    sda_lo = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(3);
    b = o_sda;
    tick(1);
    o_scl = 1'b0;
  endtask

  // also serves as repeated start, since it releases data first
  task automatic start;
    sda_lo = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    sda_lo = 1'b1;
    tick(4);
    o_scl = 1'b0;
  endtask

  task automatic stop;
    sda_lo = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    sda_lo = 1'b0;
    tick(4);
  endtask

  task automatic send_byte(logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ack = ~a;
  endtask

  task automatic write_reg(logic [7:0] ofs, logic [7:0] d,
                           logic [6:0] dev, output logic ok);
    logic a0, a1, a2;
    start();
    send_byte({dev, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // single byte read, ended by a not-acknowledge
  task automatic read_reg(logic [7:0] ofs, output logic [7:0] d);
    logic a;
    start();
    send_byte({I2C_DEV_ADDR, 1'b0}, a);
    send_byte(ofs, a);
    start();
    send_byte({I2C_DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop();
  endtask

  // two data bytes land at consecutive offsets by the auto-increment
  task automatic write_pair(logic [7:0] ofs, logic [15:0] d,
                            output logic ok);
    logic a0, a1, a2, a3;
    start();
    send_byte({I2C_DEV_ADDR, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(d[15:8], a2);
    send_byte(d[7:0], a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask

  // two-byte read: first byte acknowledged, second not
  task automatic read_pair(logic [7:0] ofs, output logic [15:0] d);
    logic a;
    start();
    send_byte({I2C_DEV_ADDR, 1'b0}, a);
    send_byte(ofs, a);
    start();
    send_byte({I2C_DEV_ADDR, 1'b1}, a);
    for (int i = 15; i >= 8; i--) get_bit(d[i]);
    put_bit(1'b0);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop();
  endtask
endmodule

// [dv/clockgen_mode_output_regs_tb_top.sv]
// self-checking bench for the clock generator register bank
module clockgen_mode_output_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cgmo_pkg::*;
  // lock waits shortened so the run stays brief
  localparam int PW = 50;
  localparam int SH = 20;

  logic        clk     = 1'b0;
  logic        nrst    = 1'b0;
  logic [2:0]  sel     = 3'h0;
  logic        pin     = 1'b0;
  logic        msel    = 1'b0;
  logic [6:0]  style   = 7'h00;
  logic [13:0] ecode   = 14'h0000;
  logic        lock    = 1'b0;
  logic [7:0]  nvm [4] = '{8'hFE, 8'hF5, 8'h82, 8'h7F};
  logic        scl, sda, sda_oe, sw_mode, pdn, valid, busy;
  logic        sda_lvl;
  logic [1:0]  naddr;
  logic [2:0]  cfg;
  logic [6:0]  susp, hiz;
  logic [27:0] edrv;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #2.5 clk = ~clk;

  cgmo_top #(
    .PWRUP_CYC (PW),
    .SHUT_CYC  (SH)
  ) u_dut (
    .i_sys_clk              (clk),
    .i_nrst                 (nrst),
    .i_scl                  (scl),
    .i_sda                  (sda),
    .o_sda                  (sda_lvl),
    .o_sda_oe               (sda_oe),
    .i_sel_pins             (sel),
    .i_shutdown_suspend_pin (pin),
    .i_shutdown_mode_sel    (msel),
    .i_disable_style_bits   (style),
    .i_edge_rate_code       (ecode),
    .i_pll_lock_ind         (lock),
    .o_nvm_addr             (naddr),
    .i_nvm_data             (nvm[naddr]),
    .o_sw_mode              (sw_mode),
    .o_active_cfg           (cfg),
    .o_out_suspend          (susp),
    .o_out_hiz              (hiz),
    .o_edge_drive           (edrv),
    .o_pll_power_down       (pdn),
    .o_clocks_valid         (valid),
    .o_load_busy            (busy)
  );

  cgmo_i2c_host u_host (
    .i_sys_clk (clk),
    .i_sda_oe  (sda_oe),
    .o_scl     (scl),
    .o_sda     (sda)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(string nm, logic [27:0] seen, logic [27:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(logic [7:0] ofs, logic [7:0] d);
    logic ok;
    u_host.write_reg(ofs, d, I2C_DEV_ADDR, ok);
    check("write_ack", ok, 1'b1);
  endtask

  task automatic rd(logic [7:0] ofs, logic [7:0] exp, string nm);
    logic [7:0] d;
    u_host.read_reg(ofs, d);
    check(nm, d, exp);
  endtask

  task automatic wait_valid(int lim, output int n);
    n = 0;
    while (valid !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    check("clocks_valid", valid, 1'b1);
    if (valid !== 1'b1) end_sim();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_load;
    int n;
    tick(8);
    check("load_busy", busy, 1'b1);
    check("nvm_addr", naddr, 2'h0);
    check("sw_mode_rst", sw_mode, 1'b0);
    check("sda_level", sda_lvl, 1'b0);
    nrst = 1'b1;
    wait_valid(PW + 12, n);
    check("lock_wait", n >= PW, 1'b1);
    check("pll_up", pdn, 1'b0);
    rd(8'h00, 8'h00, "mode");
    rd(8'h01, 8'h05, "choice");
    rd(8'h02, 8'h82, "susp_map");
    rd(8'h03, 8'h7F, "hold_n");
    check("cfg_pins", cfg, 3'h0);
    $display("test reset_load done");
  endtask

  task automatic t_mode_choice;
    sel = 3'h3;
    wr(8'h01, 8'h06);
    tick(2);
    check("cfg_hw", cfg, 3'h3);
    wr(8'h00, 8'hFF);
    tick(2);
    check("sw_mode", sw_mode, 1'b1);
    check("cfg_sw", cfg, 3'h6);
    rd(8'h00, 8'h01, "mode_rsvd");
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h07, "choice_rsvd");
    check("cfg_sw7", cfg, 3'h7);
    wr(8'h00, 8'h00);
    tick(2);
    check("cfg_back", cfg, 3'h3);
    $display("test mode_choice done");
  endtask

  task automatic t_suspend;
    style = 7'h33;
    wr(8'h02, 8'h05);
    pin = 1'b1;
    tick(3);
    check("susp_link", susp, 7'h05);
    check("hiz", hiz, 7'h01);
    pin = 1'b0;
    tick(3);
    check("susp_free", susp, 7'h00);
    wr(8'h03, 8'h7D);
    tick(2);
    check("hold", susp, 7'h02);
    pin = 1'b1;
    tick(3);
    check("hold_pin", susp, 7'h07);
    pin = 1'b0;
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h7F, "hold_rsvd");
    check("susp_off", susp, 7'h00);
    $display("test suspend done");
  endtask

  task automatic t_edge;
    for (int c = 0; c < 4; c++) begin
      ecode = {7{2'(c)}};
      tick(3);
      check("edge_drive", edrv, {7{4'h1 << c}});
    end
    ecode = 14'h1555;
    tick(3);
    check("edge_01", edrv, {7{4'h2}});
    $display("test edge done");
  endtask

  task automatic t_shutdown;
    int n;
    msel = 1'b1;
    pin = 1'b1;
    tick(3);
    check("pll_down", pdn, 1'b1);
    check("valid_off", valid, 1'b0);
    pin = 1'b0;
    wait_valid(SH + 8, n);
    check("relock", n >= SH - 1, 1'b1);
    pin = 1'b1;
    tick(3);
    lock = 1'b1;
    pin = 1'b0;
    wait_valid(6, n);
    lock = 1'b0;
    msel = 1'b0;
    $display("test shutdown done");
  endtask

  task automatic t_refuse;
    logic ok;
    u_host.write_reg(8'h10, 8'hAA, I2C_DEV_ADDR, ok);
    rd(8'h10, 8'h00, "unmapped");
    u_host.write_reg(8'h01, 8'h02, 7'h15, ok);
    check("other_addr", ok, 1'b0);
    rd(8'h01, 8'h07, "choice_kept");
    $display("test refuse done");
  endtask

  task automatic t_burst;
    logic        ok;
    logic [15:0] d;
    u_host.write_pair(8'h00, 16'h0102, ok);
    check("burst_ack", ok, 1'b1);
    u_host.read_pair(8'h00, d);
    check("burst_read", d, 16'h0102);
    tick(2);
    check("cfg_burst", cfg, 3'h2);
    $display("test burst done");
  endtask

  initial begin
    t_reset_load();
    t_mode_choice();
    t_suspend();
    t_edge();
    t_shutdown();
    t_refuse();
    t_burst();
    end_sim();
  end

  initial begin
    #400000;
    n_fail++;
    $display("wrong value run_time expected done seen timeout");
    end_sim();
  end
endmodule

// [rtl/cgmo_i2c_slave.sv]
// serial two-wire slave: register pointer, auto-increment writes and reads
module cgmo_i2c_slave
  import cgmo_pkg::*;
(
  input  wire logic   i_sys_clk,
  input  wire logic   i_nrst,
  input  wire logic   i_scl,
  input  wire logic   i_sda,
  output logic        o_sda,
  output logic        o_sda_oe,
  cgmo_regbus_if.port bus
);

  cgmo_i2c_e   st_q,    st_d;
  logic        scl_q,   sda_q;
  logic [2:0]  cnt_q,   cnt_d;
  logic [7:0]  sh_q,    sh_d;
  logic [7:0]  ptr_q,   ptr_d;
  logic        full_q,  full_d;
  logic        hptr_q,  hptr_d;
  logic        rw_q,    rw_d;
  logic        drv_q,   drv_d;
  logic        wr_q,    wr_d;
  logic [7:0]  wa_q,    wa_d;

  logic scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = i_scl & ~scl_q;
  assign scl_fall = ~i_scl & scl_q;
  assign start_c  = i_scl & scl_q & sda_q & ~i_sda;
  assign stop_c   = i_scl & scl_q & ~sda_q & i_sda;

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    full_d = full_q;
    hptr_d = hptr_q;
    rw_d   = rw_q;
    drv_d  = drv_q;
    wr_d   = 1'b0;
    wa_d   = wa_q;
    if (start_c) begin
      st_d   = CGMO_I2C_ADDR;
      cnt_d  = 3'h0;
      full_d = 1'b0;
      hptr_d = 1'b0;
      drv_d  = 1'b0;
    end else if (stop_c) begin
      st_d  = CGMO_I2C_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        CGMO_I2C_ADDR, CGMO_I2C_WR: begin
          if (scl_rise) begin
            sh_d   = {sh_q[6:0], i_sda};
            cnt_d  = cnt_q + 3'h1;
            full_d = (cnt_q == 3'h7);
          end else if (scl_fall && full_q) begin
            full_d = 1'b0;
            if (st_q == CGMO_I2C_ADDR) begin
              if (sh_q[7:1] == I2C_DEV_ADDR) begin
                rw_d  = sh_q[0];
                drv_d = 1'b1;
                st_d  = CGMO_I2C_ACKA;
              end else begin
                st_d = CGMO_I2C_IDLE;
              end
            end else begin
              drv_d = 1'b1;
              st_d  = CGMO_I2C_ACKW;
              if (!hptr_q) begin
                ptr_d  = sh_q;
                hptr_d = 1'b1;
              end else begin
                wr_d  = 1'b1;
                wa_d  = ptr_q;
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        CGMO_I2C_ACKA: begin
          if (scl_fall) begin
            cnt_d = 3'h0;
            if (rw_q) begin
              sh_d  = bus.rd_data;
              drv_d = ~bus.rd_data[7];
              st_d  = CGMO_I2C_RD;
            end else begin
              drv_d = 1'b0;
              st_d  = CGMO_I2C_WR;
            end
          end
        end
        CGMO_I2C_ACKW: begin
          if (scl_fall) begin
            drv_d = 1'b0;
            st_d  = CGMO_I2C_WR;
          end
        end
        CGMO_I2C_RD: begin
          if (scl_fall) begin
            sh_d  = {sh_q[6:0], 1'b0};
            cnt_d = cnt_q + 3'h1;
            drv_d = ~sh_q[6];
            if (cnt_q == 3'h7) begin
              drv_d = 1'b0;
              ptr_d = ptr_q + 8'h01;
              st_d  = CGMO_I2C_ACKR;
            end
          end
        end
        CGMO_I2C_ACKR: begin
          // full_q holds the master's acknowledge here
          if (scl_rise) begin
            full_d = ~i_sda;
          end else if (scl_fall) begin
            full_d = 1'b0;
            if (full_q) begin
              sh_d  = bus.rd_data;
              drv_d = ~bus.rd_data[7];
              st_d  = CGMO_I2C_RD;
            end else begin
              st_d = CGMO_I2C_IDLE;
            end
          end
        end
        default: begin
          drv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      st_q   <= CGMO_I2C_IDLE;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      cnt_q  <= 3'h0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
      full_q <= 1'b0;
      hptr_q <= 1'b0;
      rw_q   <= 1'b0;
      drv_q  <= 1'b0;
      wr_q   <= 1'b0;
      wa_q   <= 8'h00;
    end else begin
      st_q   <= st_d;
      scl_q  <= i_scl;
      sda_q  <= i_sda;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      ptr_q  <= ptr_d;
      full_q <= full_d;
      hptr_q <= hptr_d;
      rw_q   <= rw_d;
      drv_q  <= drv_d;
      wr_q   <= wr_d;
      wa_q   <= wa_d;
    end
  end

  assign o_sda       = 1'b0;
  assign o_sda_oe    = drv_q;
  assign bus.rd_addr = ptr_q;
  assign bus.wr_en   = wr_q;
  assign bus.wr_addr = wa_q;
  assign bus.wr_data = sh_q;

endmodule

// [rtl/cgmo_pkg.sv]
// shared constants, types and helpers for the clock generator register bank
package cgmo_pkg;

  // ----------------------------------------------------------------
  // register offsets, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MODE_OFS     = 8'h00;
  localparam logic [7:0] REG_CHOICE_OFS   = 8'h01;
  localparam logic [7:0] REG_SUSP_MAP_OFS = 8'h02;
  localparam logic [7:0] REG_HOLD_N_OFS   = 8'h03;

  localparam int         NUM_OUT          = 7;
  localparam int         MODE_SW_BIT      = 0;
  localparam int         CHOICE_W         = 3;
  localparam int         SUSP_SP_BIT      = 7;
  localparam int         EDGE_CODE_W      = 2;
  localparam int         EDGE_SEL_W       = 4;

  localparam logic [0:0] MODE_RST         = 1'h0;
  localparam logic [2:0] CHOICE_RST       = 3'h0;
  localparam logic [7:0] SUSP_MAP_RST     = 8'h02;
  localparam logic [6:0] HOLD_N_RST       = 7'h7F;

  // ----------------------------------------------------------------
  // serial port and non-volatile load
  // ----------------------------------------------------------------
  // value is arbitrary
  localparam logic [6:0] I2C_DEV_ADDR     = 7'h6A;
  localparam logic [1:0] NVM_LAST_IDX     = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_MHZ          = 200;
  localparam int         PWRUP_LOCK_MS    = 20;
  localparam int         SHUT_LOCK_MS     = 2;
  // longest times in cycles of the 200 MHz clock
  localparam int         PWRUP_LOCK_CYC   = PWRUP_LOCK_MS * CLK_MHZ * 1000;
  localparam int         SHUT_LOCK_CYC    = SHUT_LOCK_MS * CLK_MHZ * 1000;
  localparam int         LOCK_CNT_W       = 23;

  typedef enum logic [1:0] {
    CGMO_LOAD = 2'h0,
    CGMO_LOCK = 2'h1,
    CGMO_RUN  = 2'h3,
    CGMO_SHUT = 2'h2
  } cgmo_state_e;

  typedef enum logic [2:0] {
    CGMO_I2C_IDLE = 3'h0,
    CGMO_I2C_ADDR = 3'h1,
    CGMO_I2C_ACKA = 3'h3,
    CGMO_I2C_WR   = 3'h2,
    CGMO_I2C_ACKW = 3'h6,
    CGMO_I2C_RD   = 3'h7,
    CGMO_I2C_ACKR = 3'h5
  } cgmo_i2c_e;

  // code 0 is the fastest edge, each higher code one step slower
  function automatic logic [EDGE_SEL_W-1:0] cgmo_edge_sel(
    input logic [EDGE_CODE_W-1:0] code
  );
    cgmo_edge_sel = EDGE_SEL_W'(1) << code;
  endfunction

endpackage

// [rtl/cgmo_regbus_if.sv]
// register access path between the serial port and the register bank
interface cgmo_regbus_if;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  modport port (
    output rd_addr,
    input  rd_data,
    output wr_en,
    output wr_addr,
    output wr_data
  );

  modport regs (
    input  rd_addr,
    output rd_data,
    input  wr_en,
    input  wr_addr,
    input  wr_data
  );
endinterface

// [rtl/cgmo_top.sv]
// clock generator mode, suspend and lock sequencing register bank
// Functional notes
// - mode bit 0: hardware when clear, resets clear
// - 3-bit choice picks active configuration in software
// - linked output suspends when pin requests it
// - unlinked output stays enabled, ignores the pin unless shutdown mode is selected
// - 2-bit edge code, 00 fastest, 11 slowest
// - power-up loads nonvolatile words, locks within 20ms
// - shutdown exit relocks within 2ms
// - cleared hold bit forces suspend, overrides link
module cgmo_top
  import cgmo_pkg::*;
#(
  parameter int PWRUP_CYC = cgmo_pkg::PWRUP_LOCK_CYC,
  parameter int SHUT_CYC  = cgmo_pkg::SHUT_LOCK_CYC
) (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_nrst,
  input  wire logic                         i_scl,
  input  wire logic                         i_sda,
  output logic                              o_sda,
  output logic                              o_sda_oe,
  input  wire logic [cgmo_pkg::CHOICE_W-1:0] i_sel_pins,
  input  wire logic                         i_shutdown_suspend_pin,
  input  wire logic                         i_shutdown_mode_sel,
  input  wire logic [cgmo_pkg::NUM_OUT-1:0] i_disable_style_bits,
  input  wire logic [13:0]                  i_edge_rate_code,
  input  wire logic                         i_pll_lock_ind,
  output logic [1:0]                        o_nvm_addr,
  input  wire logic [7:0]                   i_nvm_data,
  output logic                              o_sw_mode,
  output logic [cgmo_pkg::CHOICE_W-1:0]     o_active_cfg,
  output logic [cgmo_pkg::NUM_OUT-1:0]      o_out_suspend,
  output logic [cgmo_pkg::NUM_OUT-1:0]      o_out_hiz,
  output logic [27:0]                       o_edge_drive,
  output logic                              o_pll_power_down,
  output logic                              o_clocks_valid,
  output logic                              o_load_busy
);

  import cgmo_pkg::*;

  localparam logic [LOCK_CNT_W-1:0] PWRUP_LAST =
    LOCK_CNT_W'(PWRUP_CYC - 1);
  localparam logic [LOCK_CNT_W-1:0] SHUT_LAST  =
    LOCK_CNT_W'(SHUT_CYC - 1);

  cgmo_regbus_if bus ();

  cgmo_i2c_slave u_i2c (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .o_sda     (o_sda),
    .o_sda_oe  (o_sda_oe),
    .bus       (bus)
  );

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  cgmo_state_e st_q;
  logic [1:0]  ld_idx_q, ld_idx_d;
  logic        mode_q,   mode_d;
  logic [2:0]  choice_q, choice_d;
  logic [7:0]  map_q,    map_d;
  logic [6:0]  hold_n_q, hold_n_d;
  logic        w_en;
  logic [7:0]  w_addr;
  logic [7:0]  w_data;

  // the loader owns the bank until its last word; host writes are dropped
  always_comb begin
    w_en   = (st_q == CGMO_LOAD) ? 1'b1 : bus.wr_en;
    w_addr = (st_q == CGMO_LOAD) ? {6'h00, ld_idx_q} : bus.wr_addr;
    w_data = (st_q == CGMO_LOAD) ? i_nvm_data : bus.wr_data;
    mode_d   = mode_q;
    choice_d = choice_q;
    map_d    = map_q;
    hold_n_d = hold_n_q;
    ld_idx_d = (st_q == CGMO_LOAD) ? ld_idx_q + 2'h1 : ld_idx_q;
    if (w_en) begin
      if (w_addr == REG_MODE_OFS) begin
        mode_d = w_data[MODE_SW_BIT];
      end else if (w_addr == REG_CHOICE_OFS) begin
        choice_d = w_data[CHOICE_W-1:0];
      end else if (w_addr == REG_SUSP_MAP_OFS) begin
        map_d = w_data;
      end else if (w_addr == REG_HOLD_N_OFS) begin
        hold_n_d = w_data[NUM_OUT-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      mode_q   <= MODE_RST;
      choice_q <= CHOICE_RST;
      map_q    <= SUSP_MAP_RST;
      hold_n_q <= HOLD_N_RST;
      ld_idx_q <= 2'h0;
    end else begin
      mode_q   <= mode_d;
      choice_q <= choice_d;
      map_q    <= map_d;
      hold_n_q <= hold_n_d;
      ld_idx_q <= ld_idx_d;
    end
  end

  always_comb begin
    bus.rd_data = 8'h00;
    if (bus.rd_addr == REG_MODE_OFS) begin
      bus.rd_data = {7'h00, mode_q};
    end else if (bus.rd_addr == REG_CHOICE_OFS) begin
      bus.rd_data = {5'h00, choice_q};
    end else if (bus.rd_addr == REG_SUSP_MAP_OFS) begin
      bus.rd_data = map_q;
    end else if (bus.rd_addr == REG_HOLD_N_OFS) begin
      bus.rd_data = {1'b0, hold_n_q};
    end
  end

  // ----------------------------------------------------------------
  // load and lock sequencer
  // ----------------------------------------------------------------
  cgmo_state_e             st_d;
  logic [LOCK_CNT_W-1:0]   cnt_q, cnt_d;
  logic                    from_shut_q, from_shut_d;
  logic                    shut_req;

  assign shut_req = i_shutdown_suspend_pin & i_shutdown_mode_sel;

  // lock is declared at the indicator or at the bound, whichever is first
  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    from_shut_d = from_shut_q;
    case (st_q)
      CGMO_LOAD: begin
        if (ld_idx_q == NVM_LAST_IDX) begin
          st_d        = CGMO_LOCK;
          cnt_d       = '0;
          from_shut_d = 1'b0;
        end
      end
      CGMO_LOCK: begin
        cnt_d = cnt_q + LOCK_CNT_W'(1);
        if (shut_req) begin
          st_d = CGMO_SHUT;
        end else if (i_pll_lock_ind ||
                     cnt_q == (from_shut_q ? SHUT_LAST : PWRUP_LAST)) begin
          st_d = CGMO_RUN;
        end
      end
      CGMO_RUN: begin
        if (shut_req) begin
          st_d = CGMO_SHUT;
        end
      end
      default: begin
        if (!shut_req) begin
          st_d        = CGMO_LOCK;
          cnt_d       = '0;
          from_shut_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      st_q        <= CGMO_LOAD;
      cnt_q       <= '0;
      from_shut_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      from_shut_q <= from_shut_d;
    end
  end

  // ----------------------------------------------------------------
  // per-output suspend, edge rate and configuration select
  // ----------------------------------------------------------------
  logic [NUM_OUT-1:0] susp_d, susp_q;
  logic [27:0]        edge_d, edge_q;
  logic [2:0]         cfg_d,  cfg_q;

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    always_comb begin
      susp_d[i] = ~hold_n_q[i]
                | (map_q[i] & i_shutdown_suspend_pin)
                | (st_q == CGMO_SHUT);
      edge_d[i*EDGE_SEL_W +: EDGE_SEL_W] =
        cgmo_edge_sel(i_edge_rate_code[i*EDGE_CODE_W +: EDGE_CODE_W]);
    end
  end

  assign cfg_d = mode_q ? choice_q : i_sel_pins;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      susp_q <= '0;
      edge_q <= '0;
      cfg_q  <= 3'h0;
    end else begin
      susp_q <= susp_d;
      edge_q <= edge_d;
      cfg_q  <= cfg_d;
    end
  end

  assign o_nvm_addr       = ld_idx_q;
  assign o_sw_mode        = mode_q;
  assign o_active_cfg     = cfg_q;
  assign o_out_suspend    = susp_q;
  assign o_out_hiz        = susp_q & i_disable_style_bits;
  assign o_edge_drive     = edge_q;
  assign o_pll_power_down = (st_q == CGMO_SHUT);
  assign o_clocks_valid   = (st_q == CGMO_RUN);
  assign o_load_busy      = (st_q == CGMO_LOAD);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  a_mode_reset_hw: assert property (disable iff (1'b0)
    !i_nrst |=> !mode_q) else $error("mode not hardware after reset");
  a_cfg_select: assert property (
    ##1 o_active_cfg == ($past(mode_q) ? $past(choice_q) : $past(i_sel_pins)))
    else $error("active configuration wrong");
  a_pin_suspends: assert property (
    (map_q[0] && i_shutdown_suspend_pin) |=> o_out_suspend[0])
    else $error("linked output not suspended");
  a_unlinked_run: assert property (
    (!map_q[1] && hold_n_q[1] && st_q != CGMO_SHUT) |=> !o_out_suspend[1])
    else $error("unlinked output suspended");
  a_edge_fast: assert property (
    i_edge_rate_code[1:0] == 2'h0 |=> o_edge_drive[3:0] == 4'h1)
    else $error("edge code 00 not fastest");
  a_pwrup_bound: assert property (
    (st_q == CGMO_LOCK && !from_shut_q) |-> cnt_q <= PWRUP_LAST)
    else $error("power-up lock exceeds bound");
  a_shut_bound: assert property (
    (st_q == CGMO_LOCK && from_shut_q) |-> cnt_q <= SHUT_LAST)
    else $error("shutdown relock exceeds bound");
  a_hold_forces: assert property (
    !hold_n_q[2] [*2] |-> o_out_suspend[2])
    else $error("hold did not suspend output");
  a_rsvd_zero: assert property (
    bus.rd_addr == REG_MODE_OFS |-> bus.rd_data[7:1] == 7'h00)
    else $error("reserved bits not zero");
  // busy also stands through reset, so the word index proves the length
  a_load_len: assert property (
    $fell(o_load_busy) |->
      ($past(o_nvm_addr) == 2'h3) && ($past(o_nvm_addr, 4) == 2'h0))
    else $error("load shorter than four words");

  c_sw_mode:  cover property ($rose(o_sw_mode));
  c_pin_susp: cover property (map_q[3] && i_shutdown_suspend_pin ##1
                              o_out_suspend[3]);
  c_lock:     cover property ($rose(o_clocks_valid));
  c_relock:   cover property (from_shut_q && $rose(o_clocks_valid));

endmodule
